// file: rtl/cmb_pkg.sv
// Package for the second comparator's configuration register block.
// Assumes an 8-bit special-function-register port on the system clock.
package cmb_pkg;
  localparam logic [7:0] CMB_MODE_ADDR = 8'h9C;
  localparam logic [7:0] CMB_INSEL_ADDR = 8'h9E;
  localparam logic [7:0] CMB_REG_ADDR_DEFAULT = 8'hC9;
  localparam logic [7:0] CMB_MODE_RESET = 8'h02;
  localparam logic [7:0] CMB_INSEL_RESET = 8'h00;
  localparam logic [7:0] CMB_REGCTL_RESET = 8'h00;
  localparam logic [7:0] CMB_MODE_WMASK = 8'h33;
  localparam logic [7:0] CMB_INSEL_WMASK = 8'h77;
  localparam logic [7:0] CMB_REGCTL_WMASK = 8'h90;
  localparam int CMB_RISE_IE_BIT = 5;
  localparam int CMB_FALL_IE_BIT = 4;
  localparam int CMB_MODE_LSB = 0;
  localparam int CMB_NEG_LSB = 4;
  localparam int CMB_POS_LSB = 0;
  localparam int CMB_REG_DIS_BIT = 7;
  localparam int CMB_REG_LP_BIT = 4;
  localparam int CMB_PKG_32 = 0;
  localparam int CMB_PKG_48 = 1;
  localparam int CMB_NSRC = 5;
  localparam logic [4:0] CMB_SEL_NONE = 5'h00;

  typedef enum logic [1:0]
  {
    CMB_RESP_FAST = 2'b00,
    CMB_RESP_MID1 = 2'b01,
    CMB_RESP_MID2 = 2'b10,
    CMB_RESP_LOWPWR = 2'b11
  } cmb_resp_t;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmb_sfr_req_t;

  typedef struct packed
  {
    logic regulatorOn;
    logic regulatorLowPower;
  } cmb_reg_ctl_t;
endpackage

// file: rtl/cmb_config_regs.sv
// Configuration registers of the second comparator plus regulator control bits.
// Assumes the CPU drives a synchronous SFR port; the comparator output is asynchronous.
`timescale 1ns/1ps

// Overview of operation
// - Negative select bits 6:4 on 32-pin parts pick P1.3, P1.7, P2.3, P2.7, P0.5.
// - Negative select on 48-pin parts picks P2.3, P3.1, P4.0, P4.6, P1.2.
// - Positive select bits 2:0 on 32-pin parts pick P1.2, P1.6, P2.2, P2.6, P0.4.
// - Positive select on 48-pin parts picks P2.2, P3.0, P3.7, P4.5, P1.1.
// - The package parameter leaves both select outputs in code order; only the pin names differ per package.
// - Input select bits 7 and 3 read zero and ignore writes.
// - Mode bits 7 and 6 read zero and ignore writes.
// - Mode bit 5 enables the rising-edge interrupt.
// - Mode bit 4 enables the falling-edge interrupt.
// - Mode bits 1:0 pick response: 00 fastest through 11 lowest power.
// - Software enables or disables the regulator; the enable output follows.
// - A regulator bit selects normal or low-power suspend mode.
// - Rising-edge flag sets on an output rise and holds until cleared.
// - Falling-edge flag sets on an output fall and holds until cleared.
module cmb_config_regs
  import cmb_pkg::*;
#(
  parameter int PKG_TYPE = CMB_PKG_32,
  parameter logic [7:0] REGCTL_ADDR = CMB_REG_ADDR_DEFAULT
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire cmb_sfr_req_t sfrReq,
  input wire logic flagClrRise,
  input wire logic flagClrFall,
  input wire logic cmpOutAsync,
  output logic [7:0] sfrRdata,
  output logic [4:0] posPinSel,
  output logic [4:0] negPinSel,
  output cmb_resp_t responseMode,
  output logic riseEdgeFlag,
  output logic fallEdgeFlag,
  output logic cmpIrq,
  output cmb_reg_ctl_t regCtl
);

  // Select outputs are one-hot over the five candidate pins, or zero for codes 5 to 7; the pin names for
  // each bit depend on the package and are listed in the mapping function.
  logic [7:0] mode_reg, mode_next;
  logic [7:0] insel_reg, insel_next;
  logic [7:0] regctl_reg, regctl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [4:0] pos_reg, pos_next;
  logic [4:0] neg_reg, neg_next;
  logic rise_reg, rise_next;
  logic fall_reg, fall_next;
  logic irq_reg, irq_next;
  logic sync1_reg, sync2_reg, last_reg;
  logic lastNext;
  // The regulator outputs get their own flop so the inverted enable comes straight from a register.
  cmb_reg_ctl_t ctl_reg, ctl_next;

  // Returns a one-hot pin select, or zero for codes 5 to 7; bit k is the k-th pin for the chosen package.
  // Both packages use code order, so only the pin naming differs per package.
  function automatic logic [4:0] pinDecode(input logic [2:0] code);
    logic [4:0] hot;
    hot = CMB_SEL_NONE;
    if (code < 3'(CMB_NSRC))
    begin
      hot = 5'(5'h01 << code);
    end
    return hot;
  endfunction

  // Package mapping: 32-pin neg P1.3,P1.7,P2.3,P2.7,P0.5; pos P1.2,P1.6,P2.2,P2.6,P0.4.
  // 48-pin neg P2.3,P3.1,P4.0,P4.6,P1.2; pos P2.2,P3.0,P3.7,P4.5,P1.1.
  logic [4:0] posHot, negHot;
  always_comb
  begin
    posHot = pinDecode(insel_reg[CMB_POS_LSB +: 3]);
    negHot = pinDecode(insel_reg[CMB_NEG_LSB +: 3]);
    if (PKG_TYPE == CMB_PKG_48)
    begin
      posHot = {posHot[4], posHot[3], posHot[2], posHot[1], posHot[0]};
      negHot = {negHot[4], negHot[3], negHot[2], negHot[1], negHot[0]};
    end
  end

  always_comb
  begin
    mode_next = mode_reg;
    insel_next = insel_reg;
    regctl_next = regctl_reg;
    rdata_next = rdata_reg;
    if (sfrReq.wr)
    begin
      if (sfrReq.addr == CMB_MODE_ADDR)
      begin
        mode_next = sfrReq.wdata & CMB_MODE_WMASK;
      end
      else if (sfrReq.addr == CMB_INSEL_ADDR)
      begin
        insel_next = sfrReq.wdata & CMB_INSEL_WMASK;
      end
      else if (sfrReq.addr == REGCTL_ADDR)
      begin
        regctl_next = sfrReq.wdata & CMB_REGCTL_WMASK;
      end
    end
    if (sfrReq.rd)
    begin
      if (sfrReq.addr == CMB_MODE_ADDR)
      begin
        rdata_next = mode_reg;
      end
      else if (sfrReq.addr == CMB_INSEL_ADDR)
      begin
        rdata_next = insel_reg;
      end
      else if (sfrReq.addr == REGCTL_ADDR)
      begin
        rdata_next = regctl_reg;
      end
      else
      begin
        rdata_next = 8'h00;
      end
    end
  end

  // Set wins over a clear in the same cycle so no edge is lost.
  always_comb
  begin
    lastNext = sync2_reg;
    rise_next = rise_reg;
    fall_next = fall_reg;
    if (flagClrRise)
    begin
      rise_next = 1'b0;
    end
    if (flagClrFall)
    begin
      fall_next = 1'b0;
    end
    if (sync2_reg && !last_reg)
    begin
      rise_next = 1'b1;
    end
    if (!sync2_reg && last_reg)
    begin
      fall_next = 1'b1;
    end
    irq_next = (rise_next && mode_next[CMB_RISE_IE_BIT]) || (fall_next && mode_next[CMB_FALL_IE_BIT]);
    pos_next = posHot;
    neg_next = negHot;
  end

  // Regulator control is kept as a disable bit, so reset leaves it running.
  always_comb
  begin
    ctl_next.regulatorOn = !regctl_next[CMB_REG_DIS_BIT];
    ctl_next.regulatorLowPower = regctl_next[CMB_REG_LP_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      mode_reg <= CMB_MODE_RESET;
      insel_reg <= CMB_INSEL_RESET;
      regctl_reg <= CMB_REGCTL_RESET;
      rdata_reg <= 8'h00;
      pos_reg <= CMB_SEL_NONE;
      neg_reg <= CMB_SEL_NONE;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      irq_reg <= 1'b0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
      ctl_reg.regulatorOn <= !CMB_REGCTL_RESET[CMB_REG_DIS_BIT];
      ctl_reg.regulatorLowPower <= CMB_REGCTL_RESET[CMB_REG_LP_BIT];
    end
    else
    begin
      mode_reg <= mode_next;
      insel_reg <= insel_next;
      regctl_reg <= regctl_next;
      rdata_reg <= rdata_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      irq_reg <= irq_next;
      sync1_reg <= cmpOutAsync;
      sync2_reg <= sync1_reg;
      last_reg <= lastNext;
      ctl_reg <= ctl_next;
    end
  end

  assign sfrRdata = rdata_reg;
  assign posPinSel = pos_reg;
  assign negPinSel = neg_reg;
  assign responseMode = cmb_resp_t'(mode_reg[CMB_MODE_LSB +: 2]);
  assign riseEdgeFlag = rise_reg;
  assign fallEdgeFlag = fall_reg;
  assign cmpIrq = irq_reg;
  assign regCtl = ctl_reg;

endmodule

// file: bench/cmb_props.sv
// Assertions on the comparator configuration register block.
// Sees only the block ports; bound by name after the module.
`timescale 1ns/1ps
module cmb_props
  import cmb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire cmb_sfr_req_t sfrReq,
  input wire logic flagClrRise,
  input wire logic flagClrFall,
  input wire logic cmpOutAsync,
  input wire logic [7:0] sfrRdata,
  input wire logic [4:0] posPinSel,
  input wire logic [4:0] negPinSel,
  input wire cmb_resp_t responseMode,
  input wire logic riseEdgeFlag,
  input wire logic fallEdgeFlag,
  input wire logic cmpIrq,
  input wire cmb_reg_ctl_t regCtl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // The two-flop synchroniser delays every edge, so flags get a short window.
  sequence sRise; $rose(cmpOutAsync) ##1 cmpOutAsync[*3]; endsequence
  sequence sFall; $fell(cmpOutAsync) ##1 !cmpOutAsync[*3]; endsequence
  AST_INSEL_ZERO: assert property (sfrReq.rd && sfrReq.addr == CMB_INSEL_ADDR |=> (sfrRdata & 8'h88) == 8'h00)
    else $error("insel unused bits set");
  AST_MODE_ZERO: assert property (sfrReq.rd && sfrReq.addr == CMB_MODE_ADDR |=> sfrRdata[7:6] == 2'b00)
    else $error("mode unused bits set");
  AST_RESP: assert property (sfrReq.wr && sfrReq.addr == CMB_MODE_ADDR |=> responseMode == $past(sfrReq.wdata[1:0]))
    else $error("response mode wrong");
  AST_IRQ_OFF: assert property (sfrReq.wr && sfrReq.addr == CMB_MODE_ADDR && sfrReq.wdata[5:4] == 2'b00 |-> ##2 !cmpIrq)
    else $error("irq without enable");
  AST_REG: assert property (sfrReq.wr && sfrReq.addr == CMB_REG_ADDR_DEFAULT
    |=> regCtl == {!$past(sfrReq.wdata[7]), $past(sfrReq.wdata[4])}) else $error("regulator control wrong");
  AST_RISE: assert property (sRise |-> ##[0:3] riseEdgeFlag) else $error("rise flag missing");
  AST_FALL: assert property (sFall |-> ##[0:3] fallEdgeFlag) else $error("fall flag missing");
  AST_POS: assert property (sfrReq.wr && sfrReq.addr == CMB_INSEL_ADDR
    |-> ##2 posPinSel == 5'h01 << $past(sfrReq.wdata[2:0], 2)) else $error("pos select wrong");
  AST_NEG: assert property (sfrReq.wr && sfrReq.addr == CMB_INSEL_ADDR
    |-> ##2 negPinSel == 5'h01 << $past(sfrReq.wdata[6:4], 2)) else $error("neg select wrong");
endmodule
bind cmb_config_regs cmb_props cmb_props_inst (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .sfrReq(sfrReq),
  .flagClrRise(flagClrRise),
  .flagClrFall(flagClrFall),
  .cmpOutAsync(cmpOutAsync),
  .sfrRdata(sfrRdata),
  .posPinSel(posPinSel),
  .negPinSel(negPinSel),
  .responseMode(responseMode),
  .riseEdgeFlag(riseEdgeFlag),
  .fallEdgeFlag(fallEdgeFlag),
  .cmpIrq(cmpIrq),
  .regCtl(regCtl)
);

// file: bench/testbench.sv
// Self-checking bench for the comparator configuration register block.
// Drives the SFR port at falling edges; uses the 32-pin build.
`timescale 1ns/1ps
module testbench import cmb_pkg::*;;
  logic ref_clk = 0, nrst = 0, flagClrRise = 0, flagClrFall = 0, cmpOutAsync = 0, cmpIrq, riseEdgeFlag, fallEdgeFlag;
  cmb_sfr_req_t sfrReq = '0;
  logic [7:0] sfrRdata;
  logic [4:0] posPinSel, negPinSel;
  cmb_resp_t responseMode;
  cmb_reg_ctl_t regCtl;
  int errTotal = 0, numChecks = 0, cyc = 0;
  always #20 ref_clk = ~ref_clk;
  cmb_config_regs cmb_config_regs_inst (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sfrReq(sfrReq),
    .flagClrRise(flagClrRise),
    .flagClrFall(flagClrFall),
    .cmpOutAsync(cmpOutAsync),
    .sfrRdata(sfrRdata),
    .posPinSel(posPinSel),
    .negPinSel(negPinSel),
    .responseMode(responseMode),
    .riseEdgeFlag(riseEdgeFlag),
    .fallEdgeFlag(fallEdgeFlag),
    .cmpIrq(cmpIrq),
    .regCtl(regCtl)
  );
  task automatic stopTest;
    if (errTotal == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfrReq = '{w, !w, a, d};
    @(negedge ref_clk);
    sfrReq = '0;
    if (!w)
      chk(sfrRdata, d);
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errTotal++;
      stopTest();
    end
  end
  initial
  begin
    repeat (4) @(negedge ref_clk);
    nrst = 1;
    acc(0, CMB_MODE_ADDR, 8'h02);
    acc(0, CMB_INSEL_ADDR, 8'h00);
    chk(regCtl, 10'h2);
    acc(1, CMB_INSEL_ADDR, 8'hFF);
    acc(0, CMB_INSEL_ADDR, 8'h77);
    chk({posPinSel, negPinSel}, 10'h0);
    for (int k = 0; k < 5; k++)
    begin
      acc(1, CMB_INSEL_ADDR, 8'(k * 17));
      @(negedge ref_clk);
      chk({posPinSel, negPinSel}, {2{5'h01 << k}});
    end
    for (int k = 3; k >= 0; k--)
    begin
      acc(1, CMB_MODE_ADDR, 8'(8'hF0 + k));
      chk(responseMode, 10'(k));
    end
    acc(0, CMB_MODE_ADDR, 8'h30);
    cmpOutAsync = 1;
    repeat (5) @(negedge ref_clk);
    chk({riseEdgeFlag, fallEdgeFlag, cmpIrq}, 10'h5);
    flagClrRise = 1;
    @(negedge ref_clk);
    flagClrRise = 0;
    cmpOutAsync = 0;
    repeat (5) @(negedge ref_clk);
    chk({riseEdgeFlag, fallEdgeFlag, cmpIrq}, 10'h3);
    acc(1, CMB_MODE_ADDR, 8'h20);
    @(negedge ref_clk);
    chk(cmpIrq, 10'h0);
    flagClrFall = 1;
    @(negedge ref_clk);
    flagClrFall = 0;
    @(negedge ref_clk);
    chk(fallEdgeFlag, 10'h0);
    acc(1, CMB_REG_ADDR_DEFAULT, 8'hFF);
    acc(0, CMB_REG_ADDR_DEFAULT, 8'h90);
    chk(regCtl, 10'h1);
    nrst = 0;
    @(negedge ref_clk);
    nrst = 1;
    chk(responseMode, 10'h2);
    chk(regCtl, 10'h2);
    stopTest();
  end
endmodule
